// ### bench/iid_far_model.sv
// Purpose: FPU busy and cache write-back partner of the decoder
// Assumes: Same clock and reset as the decoder
// Notes:   FPU is busy for a while after reset; each flush drains in 4 cycles
module iid_far_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic flush_req,
  output logic      fpu_busy,
  output logic      flush_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] busy_reg;
  logic [2:0] drain_reg;
  // Busy long enough after reset that a wait opcode really stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_reg <= 4'hF;
    else if (busy_reg != 4'h0) busy_reg <= busy_reg - 4'h1;
  end
  // Dirty lines take time, so the 23 base clocks start late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) drain_reg <= 3'h0;
    else if (!flush_req) drain_reg <= 3'h0;
    else if (!flush_done) drain_reg <= drain_reg + 3'h1;
  end
  assign fpu_busy   = (busy_reg != 4'h0);
  assign flush_done = flush_req && (drain_reg == 3'h3);
endmodule

// ### bench/integer_instruction_decode_tail_tb.sv
// Purpose: Self-checking bench for the decode tail
// Assumes: APB answers when pready is high; one instruction in flight
// Notes:   Expected flags are worked out by hand from the operands
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module integer_instruction_decode_tail_tb import iid_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, result, swap_value, rd;
  logic pready, pslverr, instr_ready, fpu_busy, flush_done, flush_req, done, err, wr;
  logic result_write, fault_valid, bus_lock_out, noncacheable, lock, nc;
  logic [7:0] fault_vector;
  logic [4:0] clocks_used;
  iid_instr_t instr = '0;
  iid_flags_t flags;
  int fails = 0, checks_done = 0, cyc;
  iid_decode_top u_dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr, .instr_ready, .fpu_busy,
    .flush_done, .flush_req, .done, .result, .swap_value, .result_write, .flags,
    .fault_valid, .fault_vector, .bus_lock_out, .noncacheable, .clocks_used);
  iid_far_model u_far (.pclk, .presetn, .flush_req, .fpu_busy, .flush_done);
  always #50 pclk = ~pclk;
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);  // Idle edge so a following call never reassigns psel in one step
  endtask
  function automatic iid_instr_t mk(int t, logic [7:0] o, m, logic [31:0] a, b,
                                    int me, st, logic [31:0] ea);
    return '{t[0], o, m, a, b, me[0], st[0], ea, 1'b1};
  endfunction
  // Offer one instruction, count cycles to done or fault; flags read a cycle later
  task automatic run(input iid_instr_t i);
    instr <= i; instr_valid <= 1;
    do @(posedge pclk); while (instr_ready !== 1'b1);
    instr_valid <= 0;
    cyc = 0;
    lock = 0;
    nc = 0;
    while (done !== 1'b1 && fault_valid !== 1'b1 && cyc < 200) begin
      @(posedge pclk);
      cyc++;
      lock |= bus_lock_out;
      nc |= noncacheable;
    end
    if (cyc >= 200) fails++;  // A hung instruction counts as a mismatch
    wr = result_write;
    @(posedge pclk);
  endtask
  task automatic t_regs;
    `CHK("flags_rst", FLAGS_RST, flags)
    apb(1, ADDR_CTRL, 32'hFFFFFFC0);
    apb(0, ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h000000C0, rd)
    apb(0, 12'h00C, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    apb(0, ADDR_STATUS, 32'h0);
    `CHK("status_idle", 4'h1, rd[3:0])
    $display("test regs done");
  endtask
  task automatic t_wait;
    run(mk(0, 8'h9B, 8'h00, 0, 0, 0, 0, 0));
    `CHK("wait_stalls", 1'b1, cyc > 1)
    `CHK("wait_clk", 5'h01, clocks_used)
    $display("test wait done");
  endtask
  task automatic t_alu;
    run(mk(0, 8'h2C, 8'h00, 32'h05, 32'h07, 0, 0, 0));
    `CHK("sub_res", 8'hFE, result[7:0])
    `CHK("sub_flags", 8'h15, flags)
    `CHK("sub_cyc", 1, cyc)
    run(mk(0, 8'h35, 8'h00, 32'h80000001, 32'h0, 0, 0, 0));
    `CHK("xor_res", 32'h80000001, result)
    `CHK("xor_flags", 8'h14, flags)
    `CHK("xor_cyc", 1, cyc)
    run(mk(0, 8'hA8, 8'h00, 32'hF0, 32'h0F, 0, 0, 0));
    `CHK("test_flags", 8'h0E, flags)
    `CHK("test_cyc", 1, cyc)
    `CHK("test_nowrite", 1'b0, wr)
    $display("test alu done");
  endtask
  task automatic t_modes;
    run(mk(0, 8'hFD, 8'h00, 0, 0, 0, 0, 0));
    `CHK("dir_flags", 8'h4E, flags)
    `CHK("dir_cyc", 4, cyc)
    run(mk(0, 8'hFB, 8'h00, 0, 0, 0, 0, 0));
    `CHK("int_flags", 8'h6E, flags)
    `CHK("int_cyc", 6, cyc)
    run(mk(1, 8'h00, 8'h20, 0, 0, 0, 0, 0));
    `CHK("check_read_permission_real", VEC_INVALID, fault_vector)
    run(mk(0, 8'h87, 8'h00, 1, 2, 1, 0, 0));
    `CHK("xchg_lock", 1'b1, lock)
    run(mk(1, 8'hC1, 8'h00, 32'h7FFFFFFF, 1, 0, 0, 0));
    `CHK("exchange_then_sum_res", 32'h80000000, result)
    `CHK("exchange_then_sum_swap", 32'h7FFFFFFF, swap_value)
    `CHK("exchange_then_sum_flags", 8'hF6, flags)
    `CHK("exchange_then_sum_cyc", 2, cyc)
    run(mk(0, 8'h2A, 8'h00, 0, 0, 1, 0, 32'h10000));
    `CHK("limit_gp", VEC_GP, fault_vector)
    run(mk(0, 8'h2A, 8'h00, 0, 0, 1, 1, 32'h10000));
    `CHK("limit_ss", VEC_STACK, fault_vector)
    run(mk(1, 8'h7A, 8'h00, 0, 0, 1, 0, 0));
    `CHK("save_gate", VEC_INVALID, fault_vector)
    run(mk(1, 8'h09, 8'h00, 0, 0, 0, 0, 0));
    `CHK("flush_clk", 5'h17, clocks_used)
    `CHK("flush_cyc", 1'b1, cyc > 23)
    $display("test modes done");
  endtask
  // Management gate open, then protected mode at privilege 3 over I/O level 0
  task automatic t_prot;
    apb(1, ADDR_RANGE, 32'h1);
    apb(1, ADDR_CTRL, 32'hE0);
    run(mk(1, 8'h7C, 8'h00, 0, 0, 1, 0, 0));
    `CHK("save_cyc", 21, cyc)
    `CHK("save_nc", 1'b1, nc)
    apb(1, ADDR_CTRL, 32'h07);
    run(mk(0, 8'hFB, 8'h00, 0, 0, 0, 0, 0));
    `CHK("int_priv", VEC_GP, fault_vector)
    run(mk(1, 8'h00, 8'h28, 0, 0, 0, 0, 0));
    `CHK("check_write_permission_flags", 8'hFE, flags)
    `CHK("check_write_permission_cyc", 8, cyc)
    $display("test prot done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs; t_wait; t_alu; t_modes; t_prot;
    complete_run;
  end
  // Watchdog at 3000 cycles; the whole run needs under two hundred cycles
  initial begin
    #300000;
    fails++;
    complete_run;
  end
endmodule

// ### rtl/iid_alu.sv
// Purpose: Result and arithmetic flags for subtract, test, exclusive OR and sum
// Assumes: Combinational; operands of byte width use the low eight bits
// Notes:   Auxiliary carry is produced for all ops; the caller masks it
module iid_alu
  import iid_pkg::*;
(
  input  wire iid_op_t     op,
  input  wire logic        wide,
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic      [31:0] result,
  output iid_flags_t       flags
);
  logic [32:0] sum33;
  logic [32:0] dif33;
  logic [31:0] res;
  logic        sa;
  logic        sb;
  logic        sr;
  logic        carry;

  // Result select; bit test only feeds the flags
  assign sum33  = {1'b0, a} + {1'b0, b};
  assign dif33  = {1'b0, a} - {1'b0, b};
  assign res    = (op == OP_SUB)  ? dif33[31:0] :
                  (op == OP_XOR)  ? (a ^ b) :
                  (op == OP_TEST) ? (a & b) : sum33[31:0];
  assign result = wide ? res : {24'h000000, res[7:0]};

  // Sign bits at the operand width
  assign sa    = wide ? a[31] : a[7];
  assign sb    = wide ? b[31] : b[7];
  assign sr    = wide ? res[31] : res[7];
  assign carry = (op == OP_SUB) ? (wide ? dif33[32] : (a[7:0] < b[7:0])) :
                 (wide ? sum33[32] : (9'(a[7:0]) + 9'(b[7:0])) > 9'h0FF);

  // Logical ops clear overflow and carry
  always_comb begin
    flags      = '0;
    flags.sf   = sr;
    flags.zf   = wide ? (res == 32'h00000000) : (res[7:0] == 8'h00);
    flags.pf   = ~^res[7:0];
    flags.af   = a[4] ^ b[4] ^ res[4];
    unique case (op)
      OP_SUB: begin
        flags.cf = carry;
        flags.of = (sa != sb) && (sr != sa);
      end
      OP_EXCHANGE_THEN_SUM: begin
        flags.cf = carry;
        flags.of = (sa == sb) && (sr != sa);
      end
      default: begin
        flags.cf = 1'b0;
        flags.of = 1'b0;
      end
    endcase
  end
endmodule

// ### rtl/iid_decode_top.sv
// Purpose: Decode, fault check and clock sequencing for the tail of the integer set
// Assumes: Fetch, FPU and cache handshakes are on pclk; APB slave with zero wait
// Notes:   One instruction in flight; instr_ready falls until it retires
module iid_decode_top
  import iid_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        instr_valid,
  input  wire iid_instr_t  instr,
  output logic             instr_ready,
  input  wire logic        fpu_busy,
  input  wire logic        flush_done,
  output logic             flush_req,
  output logic             done,
  output logic      [31:0] result,
  output logic      [31:0] swap_value,
  output logic             result_write,
  output iid_flags_t       flags,
  output logic             fault_valid,
  output logic      [7:0]  fault_vector,
  output logic             bus_lock_out,
  output logic             noncacheable,
  output logic      [4:0]  clocks_used
);
  iid_state_t  state_reg;
  iid_state_t  state_next;
  iid_op_t     dec_op;
  iid_op_t     op_reg;
  iid_flags_t  flags_reg;
  iid_flags_t  pend_reg;
  iid_flags_t  alu_flags;
  logic [7:0]  ctrl_reg;
  logic [31:0] range_reg;
  logic [31:0] prdata_reg;
  logic [31:0] result_reg;
  logic [31:0] swap_reg;
  logic [31:0] alu_result;
  logic [4:0]  cnt_reg;
  logic [4:0]  clk_cnt;
  logic [4:0]  used_reg;
  logic [7:0]  vec_reg;
  logic [7:0]  fault_vec;
  logic        fault_reg;
  logic        mem_reg;
  logic        wr_reg;
  logic        perm_reg;

  // Decoded opcode fields
  logic [7:0] opc;
  logic [2:0] rf;
  logic       esc;
  logic       real_mode;
  logic [1:0] current_privilege_level;
  logic [1:0] io_privilege_level;
  logic       is_save;
  logic       is_verify;
  logic       smm_ok;
  logic       limit_bad;
  logic       fault_now;
  logic       accept;
  logic       go;
  logic       finish;
  logic       apb_wr;
  logic       apb_setup;
  logic       addr_hit;

  assign opc       = instr.opcode;
  assign rf        = instr.modrm[5:3];
  assign esc       = instr.two_byte && (opc != OPC_ESCAPE);
  assign real_mode = !ctrl_reg[CTRL_PROT];
  assign current_privilege_level       = real_mode ? 2'h0 : ctrl_reg[CTRL_CPL +: 2];  // Real mode runs at level 0
  assign io_privilege_level      = ctrl_reg[CTRL_IO_PRIVILEGE_LEVEL +: 2];

  // Opcode classification, one-byte forms then escaped forms
  assign dec_op =
    (!instr.two_byte && opc == OPC_SET_DIR)                      ? OP_DIR   :
    (!instr.two_byte && opc == OPC_SET_INT)                      ? OP_INT   :
    (!instr.two_byte && opc == OPC_FPU_WAIT)                     ? OP_WAIT  :
    (!instr.two_byte && (opc[7:2] == GRP_SUB_RM || opc[7:1] == GRP_SUB_ACC ||
      (opc[7:2] == GRP_IMM && rf == REG_SUB)))                    ? OP_SUB   :
    (!instr.two_byte && (opc[7:2] == GRP_XOR_RM || opc[7:1] == GRP_XOR_ACC ||
      (opc[7:2] == GRP_IMM && rf == REG_XOR)))                    ? OP_XOR   :
    (!instr.two_byte && (opc[7:1] == GRP_TEST_RM || opc[7:1] == GRP_TEST_ACC ||
      (opc[7:1] == GRP_TEST_IMM && rf == REG_ZERO)))              ? OP_TEST  :
    (!instr.two_byte && opc[7:1] == GRP_XCHG_RM)                 ? OP_XCHG  :
    (esc && opc == OPC_SV_SEG && rf <= SREG_MAX)                 ? OP_SV_SEG:
    (esc && opc == OPC_SV_LDT && rf == REG_ZERO)                 ? OP_SV_LDT:
    (esc && opc == OPC_SV_TASK && rf == REG_ZERO)                ? OP_SV_TSK:
    (esc && opc == OPC_VERIFY && rf == REG_CHECK_READ_PERMISSION)                 ? OP_CHECK_READ_PERMISSION  :
    (esc && opc == OPC_VERIFY && rf == REG_CHECK_WRITE_PERMISSION)                 ? OP_CHECK_WRITE_PERMISSION  :
    (esc && opc == OPC_FLUSH)                                    ? OP_FLUSH :
    (esc && opc[7:1] == GRP_EXCHANGE_THEN_SUM)                                ? OP_EXCHANGE_THEN_SUM  :
                                                                   OP_BAD;

  assign is_save   = (dec_op == OP_SV_SEG) || (dec_op == OP_SV_LDT) || (dec_op == OP_SV_TSK);
  assign is_verify = (dec_op == OP_CHECK_READ_PERMISSION) || (dec_op == OP_CHECK_WRITE_PERMISSION);

  // Management access gate for the save instructions
  assign smm_ok = ctrl_reg[CTRL_MGMT_EN] && (range_reg != 32'h00000000) && (current_privilege_level == 2'h0) &&
                  (ctrl_reg[CTRL_MGMT_AC] || ctrl_reg[CTRL_MGMT_HD]);
  assign limit_bad = real_mode && instr.mem_operand && (instr.ea_last > REAL_LIMIT);

  // Fault priority: undefined and mode faults first, then privilege, then limits.
  // Only the access checks are protected-only; save, flush and the rest pass in real mode.
  assign fault_vec =
    (dec_op == OP_BAD)                                   ? VEC_INVALID :
    (real_mode && is_verify)                             ? VEC_INVALID :
    (is_save && !smm_ok)                                 ? VEC_INVALID :
    (!real_mode && dec_op == OP_INT && (current_privilege_level > io_privilege_level))     ? VEC_GP      :
    (limit_bad && instr.stack_ref)                       ? VEC_STACK   :
    limit_bad                                            ? VEC_GP      :
                                                           8'h00;
  assign fault_now = (fault_vec != 8'h00);

  assign instr_ready = (state_reg == ST_IDLE);
  assign accept      = ce && instr_valid && instr_ready;
  assign go          = accept && !fault_now;
  assign finish      = (state_reg == ST_EXEC) && (cnt_reg == 5'h00);

  // Clock cost per class; wait and flush pay theirs after their stall
  always_comb begin
    unique case (dec_op)
      OP_DIR:    clk_cnt = CLK_DIR;
      OP_INT:    clk_cnt = CLK_INT;
      OP_SV_SEG: clk_cnt = CLK_SV_SEG;
      OP_SV_LDT: clk_cnt = CLK_SV_LDT;
      OP_SV_TSK: clk_cnt = CLK_SV_TSK;
      OP_CHECK_READ_PERMISSION:   clk_cnt = CLK_VERIFY;
      OP_CHECK_WRITE_PERMISSION:   clk_cnt = CLK_VERIFY;
      OP_WAIT:   clk_cnt = CLK_WAIT;
      OP_FLUSH:  clk_cnt = CLK_FLUSH;
      OP_EXCHANGE_THEN_SUM:   clk_cnt = CLK_EXCHANGE_THEN_SUM;
      OP_XCHG:   clk_cnt = CLK_XCHG;
      default:   clk_cnt = CLK_ALU;
    endcase
  end

  iid_alu u_alu (
    .op     (dec_op),
    .wide   (opc[0]),
    .a      (instr.op_a),
    .b      (instr.op_b),
    .result (alu_result),
    .flags  (alu_flags)
  );

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (go) begin
        state_next = (dec_op == OP_WAIT)  ? ST_FPUW :
                     (dec_op == OP_FLUSH) ? ST_FLUSH : ST_EXEC;
      end
      ST_EXEC:  if (finish) state_next = ST_IDLE;
      ST_FPUW:  if (!fpu_busy) state_next = ST_EXEC;
      ST_FLUSH: if (flush_done) state_next = ST_EXEC;
      default:  state_next = ST_IDLE;
    endcase
  end

  // State and cycle counter; counter holds cost minus one entering execution
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 5'h00;
    end else if (ce) begin
      state_reg <= state_next;
      if (go || (state_reg != ST_EXEC && state_next == ST_EXEC)) begin
        cnt_reg <= (go ? clk_cnt : cnt_reg + 5'h01) - 5'h01;
      end else if (state_reg == ST_EXEC && cnt_reg != 5'h00) begin
        cnt_reg <= cnt_reg - 5'h01;
      end
    end
  end

  // Latch the instruction's work at acceptance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg     <= OP_BAD;
      pend_reg   <= FLAGS_RST;
      result_reg <= 32'h00000000;
      swap_reg   <= 32'h00000000;
      mem_reg    <= 1'b0;
      wr_reg     <= 1'b0;
      perm_reg   <= 1'b0;
      used_reg   <= 5'h00;
    end else if (ce && go) begin
      op_reg     <= dec_op;
      pend_reg   <= alu_flags;
      result_reg <= (dec_op == OP_XCHG) ? instr.op_b : alu_result;
      swap_reg   <= instr.op_a;
      mem_reg    <= instr.mem_operand;
      wr_reg     <= (dec_op == OP_SUB) || (dec_op == OP_XOR) ||
                    (dec_op == OP_EXCHANGE_THEN_SUM) || (dec_op == OP_XCHG);
      perm_reg   <= instr.perm_ok;
      used_reg   <= clk_cnt;
    end
  end

  // Flag commit on retirement; untouched flags keep their value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= FLAGS_RST;
    end else if (ce && finish) begin
      unique case (op_reg)
        OP_DIR: flags_reg.df   <= 1'b1;
        OP_INT: flags_reg.intf <= 1'b1;
        OP_SUB, OP_EXCHANGE_THEN_SUM: begin
          flags_reg <= '{of: pend_reg.of, df: flags_reg.df, intf: flags_reg.intf,
                         sf: pend_reg.sf, zf: pend_reg.zf, af: pend_reg.af,
                         pf: pend_reg.pf, cf: pend_reg.cf};
        end
        OP_TEST, OP_XOR: begin
          flags_reg.of <= 1'b0;
          flags_reg.cf <= 1'b0;
          flags_reg.sf <= pend_reg.sf;
          flags_reg.zf <= pend_reg.zf;
          flags_reg.pf <= pend_reg.pf;
        end
        OP_CHECK_READ_PERMISSION, OP_CHECK_WRITE_PERMISSION: flags_reg.zf <= perm_reg;
        default: flags_reg <= flags_reg;
      endcase
    end
  end

  // Faults are a one-cycle report; the instruction does not execute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg <= 1'b0;
      vec_reg   <= 8'h00;
    end else if (ce) begin
      fault_reg <= accept && fault_now;
      if (accept && fault_now) vec_reg <= fault_vec;
    end
  end

  // APB slave, zero wait state; read data registered during setup
  assign apb_setup = psel && !penable;
  assign apb_wr    = ce && psel && penable && pwrite;
  assign addr_hit  = (paddr == ADDR_CTRL) || (paddr == ADDR_RANGE) || (paddr == ADDR_STATUS);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= CTRL_RST;
      range_reg  <= RANGE_RST;
      prdata_reg <= 32'h00000000;
    end else if (ce) begin
      if (apb_wr && paddr == ADDR_CTRL) ctrl_reg <= pwdata[7:0];
      if (apb_wr && paddr == ADDR_RANGE) range_reg <= pwdata;
      if (apb_setup) begin
        prdata_reg <= (paddr == ADDR_CTRL)   ? {24'h000000, ctrl_reg} :
                      (paddr == ADDR_RANGE)  ? range_reg :
                      (paddr == ADDR_STATUS) ? {8'h00, vec_reg, flags_reg,
                                                4'h0, state_reg} : 32'h00000000;
      end
    end
  end

  // Outputs
  assign prdata       = prdata_reg;
  assign done         = finish;
  assign result       = result_reg;
  assign swap_value   = swap_reg;
  assign result_write = finish && wr_reg;
  assign flags        = flags_reg;
  assign fault_valid  = fault_reg;
  assign fault_vector = vec_reg;
  assign clocks_used  = used_reg;
  assign flush_req    = (state_reg == ST_FLUSH);
  assign bus_lock_out = (state_reg == ST_EXEC) && (op_reg == OP_XCHG) && mem_reg;
  assign noncacheable = (state_reg == ST_EXEC) &&
                        (op_reg == OP_SV_SEG || op_reg == OP_SV_LDT || op_reg == OP_SV_TSK);

  // Checks; a stalled clock enable abandons any attempt in flight, except in a_test_no_write
  sequence s_quiet3;
    !done [*3];
  endsequence

  a_dir_four_clocks: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    go && dec_op == OP_DIR |=> s_quiet3 ##1 done ##1 flags.df)
    else $error("direction set did not retire in 4 clocks");
  a_int_six_clocks: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    go && dec_op == OP_INT |-> ##6 done ##1 flags.intf)
    else $error("interrupt set did not retire in 6 clocks");
  a_int_priv_fault: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    accept && dec_op == OP_INT && !real_mode && current_privilege_level > io_privilege_level |=> fault_valid && fault_vector == 8'h0D)
    else $error("privilege fault 13 missing");
  a_sub_one_clock: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    go && (dec_op == OP_SUB || dec_op == OP_XOR) |=> done && result_write)
    else $error("subtract or xor not done in 1 clock");
  a_save_task_time: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    go && dec_op == OP_SV_TSK |-> ##1 noncacheable ##20 done)
    else $error("task save not done in 21 clocks");
  a_save_gate_off: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    accept && is_save && !smm_ok |=> fault_valid && fault_vector == 8'h06 && instr_ready)
    else $error("save did not fault 6");
  a_test_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    done && op_reg == OP_TEST |-> !result_write && flags.of == 1'b0)
    else $error("bit test wrote a result");
  a_real_prot_only: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    accept && is_verify && real_mode |=> fault_valid && fault_vector == 8'h06)
    else $error("verify in real mode did not fault 6");
  a_real_limit_gp: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    accept && dec_op != OP_BAD && !is_save && !is_verify && limit_bad && !instr.stack_ref
    |=> fault_valid && fault_vector == 8'h0D)
    else $error("real mode limit fault 13 missing");
  a_flush_tail_time: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    flush_req && flush_done |-> ##23 done)
    else $error("flush tail not 23 clocks");
  a_fpu_wait_stall: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    state_reg == ST_FPUW && fpu_busy |=> !done)
    else $error("wait retired while FPU busy");
endmodule

// ### rtl/iid_pkg.sv
// Purpose: Shared constants and types for the integer instruction decode tail
// Assumes: Single core clock pclk at 10 MHz, asynchronous active-low presetn
// Notes:   Clock counts are in core clocks; APB map is one 32-bit word per register
//
// How it works
// - Opcode FD sets the direction flag only and finishes in 4 clocks.
// - Opcode FB sets the interrupt flag only and finishes in 6 clocks.
// - In protected mode FB faults with vector 13 when privilege exceeds I/O level.
// - All subtract forms take 1 clock and update all six arithmetic flags.
// - 0F 78 saves a segment register with descriptor in 20 clocks, flags kept.
// - 0F 7A with reg 000 saves the local table register in 20 clocks.
// - 0F 7C with reg 000 saves the task register in 21 clocks.
// - The three save instructions fault 6 unless management mode access is allowed.
// - Bit test clears overflow and carry, updates sign zero parity, 1 clock.
// - Short bit test A8/A9 with immediate is decoded and takes 1 clock.
// - 0F 00 reg 100 checks read permission, changes only zero flag, 8 clocks.
// - 0F 00 reg 101 checks write permission; a violation clears zero, no fault.
// - Opcode 9B stalls until the FPU is idle, then costs 1 clock.
// - 0F 09 writes back dirty lines, then costs 23 further clocks.
// - 0F C0/C1 swaps operands, stores the sum, updates six flags, 2 clocks.
// - Exchange with a memory operand drives the bus lock pin without a prefix.
// - All exclusive OR forms clear overflow and carry and take 1 clock.
// - A protected-only instruction executed in real mode faults with vector 6.
// - Real mode operand beyond FFFFH in code or data segment faults 13.
// - Real mode operand beyond the stack segment limit faults 12.
// - Permitted system instructions run normally in real mode without fault 6.
// - Management memory accesses by the save instructions are non-cacheable.
package iid_pkg;

  // Opcode bytes and opcode groups
  localparam logic [7:0] OPC_ESCAPE   = 8'h0F;
  localparam logic [7:0] OPC_SET_DIR  = 8'hFD;
  localparam logic [7:0] OPC_SET_INT  = 8'hFB;
  localparam logic [7:0] OPC_FPU_WAIT = 8'h9B;
  localparam logic [7:0] OPC_SV_SEG   = 8'h78;
  localparam logic [7:0] OPC_SV_LDT   = 8'h7A;
  localparam logic [7:0] OPC_SV_TASK  = 8'h7C;
  localparam logic [7:0] OPC_VERIFY   = 8'h00;
  localparam logic [7:0] OPC_FLUSH    = 8'h09;
  localparam logic [5:0] GRP_SUB_RM   = 6'h0A;  // 28..2B
  localparam logic [6:0] GRP_SUB_ACC  = 7'h16;  // 2C/2D
  localparam logic [5:0] GRP_XOR_RM   = 6'h0C;  // 30..33
  localparam logic [6:0] GRP_XOR_ACC  = 7'h1A;  // 34/35
  localparam logic [5:0] GRP_IMM      = 6'h20;  // 80..83
  localparam logic [6:0] GRP_TEST_RM  = 7'h42;  // 84/85
  localparam logic [6:0] GRP_XCHG_RM  = 7'h43;  // 86/87
  localparam logic [6:0] GRP_TEST_IMM = 7'h7B;  // F6/F7
  localparam logic [6:0] GRP_TEST_ACC = 7'h54;  // A8/A9
  localparam logic [6:0] GRP_EXCHANGE_THEN_SUM     = 7'h60;  // 0F C0/C1
  localparam logic [2:0] REG_SUB      = 3'h5;
  localparam logic [2:0] REG_XOR      = 3'h6;
  localparam logic [2:0] REG_ZERO     = 3'h0;
  localparam logic [2:0] REG_CHECK_READ_PERMISSION     = 3'h4;
  localparam logic [2:0] REG_CHECK_WRITE_PERMISSION     = 3'h5;
  localparam logic [2:0] SREG_MAX     = 3'h5;
  localparam logic [1:0] MOD_REG      = 2'h3;

  // Fault vectors and real mode limit
  localparam logic [7:0]  VEC_INVALID = 8'h06;
  localparam logic [7:0]  VEC_STACK   = 8'h0C;
  localparam logic [7:0]  VEC_GP      = 8'h0D;
  localparam logic [31:0] REAL_LIMIT  = 32'h0000FFFF;

  // Clock counts
  localparam logic [4:0] CLK_DIR    = 5'h04;
  localparam logic [4:0] CLK_INT    = 5'h06;
  localparam logic [4:0] CLK_ALU    = 5'h01;
  localparam logic [4:0] CLK_SV_SEG = 5'h14;
  localparam logic [4:0] CLK_SV_LDT = 5'h14;
  localparam logic [4:0] CLK_SV_TSK = 5'h15;
  localparam logic [4:0] CLK_VERIFY = 5'h08;
  localparam logic [4:0] CLK_WAIT   = 5'h01;
  localparam logic [4:0] CLK_FLUSH  = 5'h17;
  localparam logic [4:0] CLK_EXCHANGE_THEN_SUM   = 5'h02;
  localparam logic [4:0] CLK_XCHG   = 5'h02;

  // APB register map and control fields
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_RANGE  = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam int CTRL_PROT    = 0;
  localparam int CTRL_CPL     = 1;
  localparam int CTRL_IO_PRIVILEGE_LEVEL    = 3;
  localparam int CTRL_MGMT_EN = 5;
  localparam int CTRL_MGMT_AC = 6;
  localparam int CTRL_MGMT_HD = 7;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [31:0] RANGE_RST = 32'h00000000;
  localparam logic [7:0]  FLAGS_RST = 8'h00;

  typedef enum logic [3:0] {
    OP_BAD, OP_DIR, OP_INT, OP_SUB, OP_TEST, OP_XOR, OP_EXCHANGE_THEN_SUM, OP_XCHG,
    OP_SV_SEG, OP_SV_LDT, OP_SV_TSK, OP_CHECK_READ_PERMISSION, OP_CHECK_WRITE_PERMISSION, OP_WAIT, OP_FLUSH
  } iid_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_EXEC = 4'h2, ST_FPUW = 4'h4, ST_FLUSH = 4'h8
  } iid_state_t;

  typedef struct packed {
    logic        of;
    logic        df;
    logic        intf;
    logic        sf;
    logic        zf;
    logic        af;
    logic        pf;
    logic        cf;
  } iid_flags_t;

  typedef struct packed {
    logic        two_byte;     // 0F escape seen
    logic [7:0]  opcode;
    logic [7:0]  modrm;
    logic [31:0] op_a;         // Destination operand value
    logic [31:0] op_b;         // Source or immediate, already extended
    logic        mem_operand;  // Operand is in memory
    logic        stack_ref;    // Memory operand is in the stack segment
    logic [31:0] ea_last;      // Offset of last byte touched
    logic        perm_ok;      // Selector passes the access check
  } iid_instr_t;

endpackage
